/* File: tpw_map.vh */
// Offsets, field positions, reset values and timing for the wake block
`ifndef TPW_MAP_VH
`define TPW_MAP_VH

`define TPW_OFF_STS 8'h00
`define TPW_OFF_EN 8'h04
`define TPW_OFF_CTRL 8'h08
`define TPW_OFF_RET 8'h0C
`define TPW_OFF_LAMP 8'h10
`define TPW_OFF_KEY 8'h14
`define TPW_OFF_STATE 8'h18
`define TPW_OFF_CLK 8'hF0

`define TPW_EV_RING1 0
`define TPW_EV_RING2 1
`define TPW_EV_KBD 2
`define TPW_EV_MOUSE 3
`define TPW_EV_KEY 4
`define TPW_EV_TACH0 5
`define TPW_EV_TACH1 6
`define TPW_EV_RET 7
`define TPW_EV_GPIO_LO 8
`define TPW_NEV 16

`define TPW_CTRL_ACT 0
`define TPW_CTRL_FDAT_LO 1
`define TPW_CTRL_FALT_LO 3
`define TPW_CTRL_FINV_LO 5
`define TPW_RET_DIR 0
`define TPW_RET_INV 1
`define TPW_RET_OD 2
`define TPW_RET_ALT 3
`define TPW_RET_DAT 4

`define TPW_RST_STS 16'h0000
`define TPW_RST_EN 16'h0000
`define TPW_RST_CTRL 7'h00
`define TPW_RST_RET 5'h00
`define TPW_RST_LAMP 4'h0
`define TPW_RST_KEY 8'h00
`define TPW_RST_CLK 1'b0

`define TPW_LAMP_OFF 2'b00
`define TPW_LAMP_BLINK 2'b01
`define TPW_LAMP_ON 2'b10

`define TPW_MCLK_HZ 40000000
`define TPW_SLOW_HZ 32768
`define TPW_INT_DIV (`TPW_MCLK_HZ / `TPW_SLOW_HZ)
`define TPW_DIV_LAST 11'h4C3
`define TPW_BLINK_BIT 13
`define TPW_KBD_FRAME 4'hB

`endif

/* File: tpw_sync.v */
// Two-flop synchroniser bank for pin inputs
`timescale 1ns/1ps
module tpw_sync #(
  parameter W = 1
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire [W-1:0] d_i,
  output wire [W-1:0] q_o
);
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : bit_g
      reg s1_reg;
      reg s2_reg;
      always @(posedge clk_i) begin
        if (!rst_n_i) begin
          s1_reg <= 1'b0;
          s2_reg <= 1'b0;
        end else begin
          s1_reg <= d_i[g];
          s2_reg <= s1_reg;
        end
      end
      assign q_o[g] = s2_reg;
    end
  endgenerate
endmodule

/* File: tpw_slowtick.v */
// 32 kHz tick from the external slow clock or the internal divider
`timescale 1ns/1ps
`include "tpw_map.vh"
module tpw_slowtick (
  input wire clk_i,
  input wire rst_n_i,
  input wire slow_pin_i,
  input wire sel_int_i,
  input wire vcc_good_i,
  output reg tick_o
);
  localparam [10:0] DIV_LAST = `TPW_DIV_LAST;
  reg pin_prev_reg;
  reg [10:0] div_reg;
  reg [10:0] div_next;
  reg tick_next;

  always @* begin
    div_next = div_reg;
    tick_next = 1'b0;
    if (!sel_int_i) begin
      div_next = 11'h000;
      tick_next = slow_pin_i & ~pin_prev_reg;
    end else if (vcc_good_i) begin
      // Derived source exists only while the main supply is up
      if (div_reg == DIV_LAST) begin
        div_next = 11'h000;
        tick_next = 1'b1;
      end else begin
        div_next = div_reg + 11'h001;
      end
    end else begin
      div_next = 11'h000;
    end
  end

  always @(posedge clk_i) begin
    if (!rst_n_i) begin
      pin_prev_reg <= 1'b0;
      div_reg <= 11'h000;
      tick_o <= 1'b0;
    end else begin
      pin_prev_reg <= slow_pin_i;
      div_reg <= div_next;
      tick_o <= tick_next;
    end
  end
endmodule

/* File: tpw_top.v */
// Trickle-powered wake sources, event output and pin retention
//
// Functional notes
// - Under trickle power alone, enabled wake sources pull the event output low.
// - Sources: both ring indicators, keyboard, mouse, key match, tachs, GPIOs.
// - Tach wakes work with main off on the external slow clock only; software clears tach enables first.
// - Main-supply pin drivers are input-only under trickle power.
// - Listed GPIO pins are wake inputs only; IR and lamp pins excepted.
// - Fan pins come up as low outputs after main reset or hard reset.
// - IR pin comes up low after any of the three resets, never wakes.
// - Fan pins fall back to plain non-inverted output when main is lost.
// - Retained pin drops alternate function, keeps direction, invert, type.
// - Keyboard-reset, gate-A20, drive-density pins have no wake path.
// - IR pins low with main off; follow port-2 transmit once activated.
// - Lamp logic keeps driving its two pins under trickle power.
// - Event output keeps working with only trickle power present.
// - Event, runtime registers, key, lamp, tach logic keep state on main loss.
// - Bit 0 at 0xF0 picks slow clock: 0 external, 1 internal derived.
// - With external slow clock absent, key/lamp/tach stop without main.
// - Trickle reset initialises IR, event configuration and event logic.
// - Without power-good, bus reads and writes are ignored; wake runs on.
`timescale 1ns/1ps
`include "tpw_map.vh"
module tpw_top (
  input wire MCLK_I,
  input wire RST_N_I,
  input wire [7:0] AVS_ADDRESS_I,
  input wire AVS_READ_I,
  input wire AVS_WRITE_I,
  input wire [31:0] AVS_WRITEDATA_I,
  input wire [3:0] AVS_BYTEENABLE_I,
  output reg [31:0] AVS_READDATA_O,
  output reg AVS_WAITREQUEST_O,
  input wire VCC_GOOD_I,
  input wire MAIN_POR_I,
  input wire HARD_RST_I,
  input wire RING_IND_PORT1_N_I,
  input wire RING_IND_PORT2_N_I,
  input wire KEYBOARD_DATA_LINE_I,
  input wire KEYBOARD_CLK_I,
  input wire MOUSE_DATA_LINE_I,
  input wire [1:0] TACH_I,
  input wire [7:0] WAKE_GPIO_I,
  input wire SLOW_CLK_I,
  input wire RET_GPIO_I,
  input wire UART2_TXD_I,
  input wire [1:0] FAN_PWM_I,
  input wire RET_ALT_I,
  output reg WAKE_EVENT_OUT_N_O,
  output reg WAKE_EVENT_OE_O,
  output reg FAN_CTL_PIN_A_O,
  output reg FAN_CTL_PIN_B_O,
  output reg IR_TX_GPIO_A_O,
  output reg IR_TX_GPIO_B_O,
  output reg LAMP_PIN_A_O,
  output reg LAMP_PIN_B_O,
  output reg RET_GPIO_O,
  output reg RET_GPIO_OE_O
);
  localparam NS = 20;

  wire [NS-1:0] pin_raw;
  wire [NS-1:0] pin_s;
  wire ring1_n;
  wire ring2_n;
  wire keyboard_data_line;
  wire kclk;
  wire mouse_data_line;
  wire [1:0] tach;
  wire [7:0] gpio;
  wire slow_pin;
  wire vcc_good;
  wire main_rst;
  wire ret_in;
  wire tick;

  // Wake, slow-clock, power-good, reset and retained pins are sampled; only wake sources and the retained pin feed flags
  assign pin_raw = {RET_GPIO_I, HARD_RST_I, MAIN_POR_I, VCC_GOOD_I,
                    SLOW_CLK_I, WAKE_GPIO_I, TACH_I, MOUSE_DATA_LINE_I,
                    KEYBOARD_CLK_I, KEYBOARD_DATA_LINE_I,
                    RING_IND_PORT2_N_I, RING_IND_PORT1_N_I};

  tpw_sync #(.W(NS)) u_sync (
    .clk_i(MCLK_I),
    .rst_n_i(RST_N_I),
    .d_i(pin_raw),
    .q_o(pin_s)
  );

  assign ring1_n = pin_s[0];
  assign ring2_n = pin_s[1];
  assign keyboard_data_line = pin_s[2];
  assign kclk = pin_s[3];
  assign mouse_data_line = pin_s[4];
  assign tach = pin_s[6:5];
  assign gpio = pin_s[14:7];
  assign slow_pin = pin_s[15];
  assign vcc_good = pin_s[16];
  assign main_rst = pin_s[17] | pin_s[18];
  assign ret_in = pin_s[19];

  reg [15:0] sts_reg;
  reg [15:0] sts_next;
  reg [15:0] en_reg;
  reg [6:0] ctrl_reg;
  reg [4:0] ret_reg;
  reg [3:0] lamp_reg;
  reg [7:0] key_reg;
  reg clksel_reg;

  tpw_slowtick u_tick (
    .clk_i(MCLK_I),
    .rst_n_i(RST_N_I),
    .slow_pin_i(slow_pin),
    .sel_int_i(clksel_reg),
    .vcc_good_i(vcc_good),
    .tick_o(tick)
  );

  // Bus slave: one wait cycle, then a one-cycle answer
  wire req;
  wire acc;
  wire bus_ok;
  wire [31:0] bmask;
  assign req = AVS_READ_I | AVS_WRITE_I;
  assign acc = req & ~AVS_WAITREQUEST_O;
  assign bus_ok = vcc_good;
  assign bmask = {{8{AVS_BYTEENABLE_I[3]}}, {8{AVS_BYTEENABLE_I[2]}},
                  {8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};
  wire wr_ok;
  wire [31:0] wd;
  assign wr_ok = acc & AVS_WRITE_I & bus_ok;
  assign wd = AVS_WRITEDATA_I & bmask;

  reg [31:0] rd_next;
  wire wake_any;
  assign wake_any = |(sts_reg & en_reg);

  always @* begin
    rd_next = 32'h0000_0000;
    if (bus_ok) begin
      case (AVS_ADDRESS_I)
        `TPW_OFF_STS: rd_next = {16'h0000, sts_reg};
        `TPW_OFF_EN: rd_next = {16'h0000, en_reg};
        `TPW_OFF_CTRL: rd_next = {25'h000_0000, ctrl_reg};
        `TPW_OFF_RET: rd_next = {27'h000_0000, ret_reg};
        `TPW_OFF_LAMP: rd_next = {28'h000_0000, lamp_reg};
        `TPW_OFF_KEY: rd_next = {24'h00_0000, key_reg};
        `TPW_OFF_STATE: rd_next = {27'h000_0000, tach, ret_in,
                                   wake_any, vcc_good};
        `TPW_OFF_CLK: rd_next = {31'h0000_0000, clksel_reg};
        default: rd_next = 32'h0000_0000;
      endcase
    end
  end

  always @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      AVS_WAITREQUEST_O <= 1'b1;
      AVS_READDATA_O <= 32'h0000_0000;
    end else if (req && AVS_WAITREQUEST_O) begin
      AVS_WAITREQUEST_O <= 1'b0;
      AVS_READDATA_O <= rd_next;
    end else begin
      AVS_WAITREQUEST_O <= 1'b1;
    end
  end

  // Wake source edge detection
  reg ring1_prev_reg;
  reg ring2_prev_reg;
  reg keyboard_data_line_prev_reg;
  reg kclk_prev_reg;
  reg mouse_data_line_prev_reg;
  reg ret_prev_reg;
  reg [7:0] gpio_prev_reg;
  reg [1:0] tach_smp_reg;
  reg [10:0] kshift_reg;
  reg [3:0] kcnt_reg;
  reg key_hit_reg;
  reg [13:0] blink_reg;

  wire slow_ok;
  wire kfall = kclk_prev_reg & ~kclk;
  wire [10:0] kframe = {keyboard_data_line, kshift_reg[10:1]};
  wire [15:0] ev;
  // Slow-clock functions stop without main if the external clock is absent
  assign slow_ok = ~clksel_reg | vcc_good;

  assign ev[`TPW_EV_RING1] = ring1_prev_reg & ~ring1_n;
  assign ev[`TPW_EV_RING2] = ring2_prev_reg & ~ring2_n;
  assign ev[`TPW_EV_KBD] = keyboard_data_line_prev_reg & ~keyboard_data_line;
  assign ev[`TPW_EV_MOUSE] = mouse_data_line_prev_reg & ~mouse_data_line;
  assign ev[`TPW_EV_KEY] = key_hit_reg;
  // Tachs raise events on either edge at the slow tick; without main only on the external clock
  assign ev[`TPW_EV_TACH0] = tick & (tach_smp_reg[0] ^ tach[0]);
  assign ev[`TPW_EV_TACH1] = tick & (tach_smp_reg[1] ^ tach[1]);
  assign ev[`TPW_EV_RET] = ret_prev_reg ^ ret_in;
  assign ev[15:8] = gpio_prev_reg ^ gpio;

  always @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      ring1_prev_reg <= 1'b0;
      ring2_prev_reg <= 1'b0;
      keyboard_data_line_prev_reg <= 1'b0;
      kclk_prev_reg <= 1'b0;
      mouse_data_line_prev_reg <= 1'b0;
      ret_prev_reg <= 1'b0;
      gpio_prev_reg <= 8'h00;
      tach_smp_reg <= 2'b00;
    end else begin
      ring1_prev_reg <= ring1_n;
      ring2_prev_reg <= ring2_n;
      keyboard_data_line_prev_reg <= keyboard_data_line;
      kclk_prev_reg <= kclk;
      mouse_data_line_prev_reg <= mouse_data_line;
      ret_prev_reg <= ret_in;
      gpio_prev_reg <= gpio;
      if (tick) begin
        tach_smp_reg <= tach;
      end
    end
  end

  // Specific-key detector: frame of 11 bits, data byte in bits 8:1
  always @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      kshift_reg <= 11'h000;
      kcnt_reg <= 4'h0;
      key_hit_reg <= 1'b0;
    end else begin
      key_hit_reg <= 1'b0;
      if (!slow_ok) begin
        kcnt_reg <= 4'h0;
      end else if (kfall) begin
        kshift_reg <= kframe;
        if (kcnt_reg == `TPW_KBD_FRAME - 4'h1) begin
          kcnt_reg <= 4'h0;
          key_hit_reg <= (kframe[8:1] == key_reg);
        end else begin
          kcnt_reg <= kcnt_reg + 4'h1;
        end
      end
    end
  end

  // Sticky flags; a new event beats a simultaneous clear
  always @* begin
    sts_next = sts_reg | ev;
    if (wr_ok && AVS_ADDRESS_I == `TPW_OFF_STS) begin
      sts_next = (sts_reg & ~wd[15:0]) | ev;
    end
  end

  // Trickle-reset state, kept across main loss
  always @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      sts_reg <= `TPW_RST_STS;
      en_reg <= `TPW_RST_EN;
      ret_reg <= `TPW_RST_RET;
      lamp_reg <= `TPW_RST_LAMP;
      key_reg <= `TPW_RST_KEY;
      clksel_reg <= `TPW_RST_CLK;
    end else begin
      sts_reg <= sts_next;
      if (wr_ok) begin
        case (AVS_ADDRESS_I)
          `TPW_OFF_EN: en_reg <= (en_reg & ~bmask[15:0]) | wd[15:0];
          `TPW_OFF_RET: ret_reg <= wd[4:0];
          `TPW_OFF_LAMP: lamp_reg <= wd[3:0];
          `TPW_OFF_KEY: key_reg <= wd[7:0];
          `TPW_OFF_CLK: clksel_reg <= wd[0];
          default: key_reg <= key_reg;
        endcase
      end
    end
  end

  // Control reset also by main reset and hard reset
  always @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      ctrl_reg <= `TPW_RST_CTRL;
    end else if (main_rst) begin
      ctrl_reg <= `TPW_RST_CTRL;
    end else if (wr_ok && AVS_ADDRESS_I == `TPW_OFF_CTRL) begin
      ctrl_reg <= (ctrl_reg & ~bmask[6:0]) | wd[6:0];
    end
  end

  // Lamp blink divider runs on the slow tick
  always @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      blink_reg <= 14'h0000;
    end else if (tick) begin
      blink_reg <= blink_reg + 14'h0001;
    end
  end

  function lamp_val;
    input [1:0] mode;
    input blink;
    begin
      case (mode)
        `TPW_LAMP_BLINK: lamp_val = blink;
        `TPW_LAMP_ON: lamp_val = 1'b1;
        default: lamp_val = 1'b0;
      endcase
    end
  endfunction

  // Pin drivers
  wire act = ctrl_reg[`TPW_CTRL_ACT];
  wire [1:0] fdat = ctrl_reg[`TPW_CTRL_FDAT_LO +: 2];
  wire [1:0] falt = ctrl_reg[`TPW_CTRL_FALT_LO +: 2];
  wire [1:0] finv = ctrl_reg[`TPW_CTRL_FINV_LO +: 2];
  wire [1:0] fan_val;
  wire ret_v;
  // Without main: plain non-inverted GPIO output
  assign fan_val = vcc_good ?
                   (((falt & FAN_PWM_I) | (~falt & fdat)) ^ finv) : fdat;
  // Without main the alternate function is dropped
  assign ret_v = ((vcc_good & ret_reg[`TPW_RET_ALT]) ? RET_ALT_I :
                  ret_reg[`TPW_RET_DAT]) ^ ret_reg[`TPW_RET_INV];

  always @(posedge MCLK_I) begin
    if (!RST_N_I) begin
      WAKE_EVENT_OUT_N_O <= 1'b1;
      WAKE_EVENT_OE_O <= 1'b0;
      FAN_CTL_PIN_A_O <= 1'b0;
      FAN_CTL_PIN_B_O <= 1'b0;
      IR_TX_GPIO_A_O <= 1'b0;
      IR_TX_GPIO_B_O <= 1'b0;
      LAMP_PIN_A_O <= 1'b0;
      LAMP_PIN_B_O <= 1'b0;
      RET_GPIO_O <= 1'b0;
      RET_GPIO_OE_O <= 1'b0;
    end else begin
      // Open-drain event pin, independent of main supply
      WAKE_EVENT_OUT_N_O <= ~wake_any;
      WAKE_EVENT_OE_O <= wake_any;
      if (main_rst) begin
        FAN_CTL_PIN_A_O <= 1'b0;
        FAN_CTL_PIN_B_O <= 1'b0;
      end else begin
        FAN_CTL_PIN_A_O <= fan_val[0];
        FAN_CTL_PIN_B_O <= fan_val[1];
      end
      // Low until port 2 is active and main is up
      IR_TX_GPIO_A_O <= vcc_good & act & ~main_rst & UART2_TXD_I;
      IR_TX_GPIO_B_O <= vcc_good & act & ~main_rst & UART2_TXD_I;
      // Lamp pins keep driving under trickle power
      LAMP_PIN_A_O <= lamp_val(lamp_reg[1:0], blink_reg[`TPW_BLINK_BIT]);
      LAMP_PIN_B_O <= lamp_val(lamp_reg[3:2], blink_reg[`TPW_BLINK_BIT]);
      // Main-powered driver: input-only under trickle
      if (ret_reg[`TPW_RET_OD]) begin
        RET_GPIO_O <= 1'b0;
        RET_GPIO_OE_O <= vcc_good & ret_reg[`TPW_RET_DIR] & ~ret_v;
      end else begin
        RET_GPIO_O <= ret_v;
        RET_GPIO_OE_O <= vcc_good & ret_reg[`TPW_RET_DIR];
      end
    end
  end
endmodule

/* File: tpw_checker.sv */
// Port-level assertions for the wake block
`timescale 1ns/1ps
module tpw_checker (
  input wire MCLK_I,
  input wire RST_N_I,
  input wire AVS_READ_I,
  input wire AVS_WRITE_I,
  input wire [31:0] AVS_READDATA_O,
  input wire AVS_WAITREQUEST_O,
  input wire VCC_GOOD_I,
  input wire MAIN_POR_I,
  input wire HARD_RST_I,
  input wire WAKE_EVENT_OUT_N_O,
  input wire WAKE_EVENT_OE_O,
  input wire FAN_CTL_PIN_A_O,
  input wire FAN_CTL_PIN_B_O,
  input wire IR_TX_GPIO_A_O,
  input wire IR_TX_GPIO_B_O,
  input wire RET_GPIO_OE_O
);
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);
  sequence req_s;
    (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O;
  endsequence
  sequence trickle_s;
    (!VCC_GOOD_I && !MAIN_POR_I && !HARD_RST_I) [*5];
  endsequence
  sequence main_rst_s;
    (MAIN_POR_I || HARD_RST_I) [*4];
  endsequence
  AST_ANSWER_ONE: assert property (req_s |=> !AVS_WAITREQUEST_O)
    else $error("bus answer not in one cycle");
  AST_ANSWER_BACK: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
    else $error("waitrequest low too long");
  AST_READ_ZERO: assert property (trickle_s ##0 req_s ##0 AVS_READ_I
    |=> AVS_READDATA_O == 32'h0000_0000)
    else $error("read answered data without main power");
  AST_OD_PAIR: assert property (WAKE_EVENT_OE_O == !WAKE_EVENT_OUT_N_O)
    else $error("event enable and level disagree");
  AST_CLEAR_CAUSE: assert property ($rose(WAKE_EVENT_OUT_N_O)
    |-> $past(AVS_WRITE_I, 2) || $past(AVS_WRITE_I, 3))
    else $error("event released without a software write");
  AST_IR_TRICKLE: assert property ((!VCC_GOOD_I) [*4]
    |=> !IR_TX_GPIO_A_O && !IR_TX_GPIO_B_O)
    else $error("IR pin not low without main power");
  AST_IR_PAIR: assert property (IR_TX_GPIO_A_O == IR_TX_GPIO_B_O)
    else $error("IR pins differ");
  AST_MAIN_RST: assert property (main_rst_s |=> !FAN_CTL_PIN_A_O
    && !FAN_CTL_PIN_B_O && !IR_TX_GPIO_A_O)
    else $error("fan or IR pin high in main reset");
  AST_FAN_PLAIN: assert property (trickle_s
    |-> $stable(FAN_CTL_PIN_A_O) && $stable(FAN_CTL_PIN_B_O))
    else $error("fan pin follows alternate drive without main");
  AST_RET_OFF: assert property (trickle_s |-> !RET_GPIO_OE_O)
    else $error("retained pin driven without main power");
endmodule

bind tpw_top tpw_checker u_chk (.MCLK_I, .RST_N_I, .AVS_READ_I,
  .AVS_WRITE_I, .AVS_READDATA_O, .AVS_WAITREQUEST_O, .VCC_GOOD_I,
  .MAIN_POR_I, .HARD_RST_I, .WAKE_EVENT_OUT_N_O, .WAKE_EVENT_OE_O,
  .FAN_CTL_PIN_A_O, .FAN_CTL_PIN_B_O, .IR_TX_GPIO_A_O, .IR_TX_GPIO_B_O,
  .RET_GPIO_OE_O);

/* File: tpw_pme_host.sv */
// Chipset side of the open-drain wake line
`timescale 1ns/1ps
module tpw_pme_host (
  input wire clk_i,
  input wire out_n_i,
  input wire oe_i,
  output wire line_o,
  output reg [7:0] wakes_o
);
  reg line_q = 1'b1;
  // Pull-up holds the line unless the device sinks it
  assign line_o = (oe_i && !out_n_i) ? 1'b0 : 1'b1;
  initial wakes_o = 8'h00;
  always @(posedge clk_i) begin
    line_q <= line_o;
    if (line_q && !line_o)
      wakes_o <= wakes_o + 8'h01;
  end
endmodule

/* File: tpw_top_tb.sv */
// Testbench for the trickle wake block
`timescale 1ns/1ps
module tpw_top_tb;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg [7:0] adr = 8'h00;
  reg rd_en = 1'b0;
  reg wr_en = 1'b0;
  reg [31:0] wdat = 32'h0000_0000;
  reg vcc = 1'b1;
  reg mpor = 1'b0;
  reg hrst = 1'b0;
  reg [3:0] src_n = 4'hF;
  reg [1:0] tach = 2'b00;
  reg [7:0] gp = 8'h00;
  reg [2:0] gi = 3'h0;
  reg slow = 1'b0;
  reg [3:0] u = 4'h0;
  reg kclk = 1'b1;
  reg rg = 1'b0;
  reg [9:0] sc = 10'h000;
  reg [31:0] seed = 32'h0000_99cc;
  reg [31:0] expq [$];
  integer miscompares = 0;
  integer total_checks = 0;
  wire [31:0] rdat;
  wire [7:0] wakes;
  wire wait_rq, ev_n, ev_oe, fan_a, fan_b, ir_a, ir_b;
  wire lamp_a, lamp_b, ret_o, ret_oe, pme;

  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction

  always #12.5 clk = ~clk;
  // Random drive; external slow clock near 32 kHz
  always @(posedge clk) begin
    seed <= xs(seed);
    sc <= (sc == 10'd609) ? 10'd0 : sc + 10'd1;
    if (sc == 10'd609)
      slow <= ~slow;
  end

  tpw_top dut (.MCLK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(adr),
    .AVS_READ_I(rd_en), .AVS_WRITE_I(wr_en), .AVS_WRITEDATA_I(wdat),
    .AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(rdat),
    .AVS_WAITREQUEST_O(wait_rq), .VCC_GOOD_I(vcc), .MAIN_POR_I(mpor),
    .HARD_RST_I(hrst), .RING_IND_PORT1_N_I(src_n[0]),
    .RING_IND_PORT2_N_I(src_n[1]), .KEYBOARD_DATA_LINE_I(src_n[2]),
    .KEYBOARD_CLK_I(kclk), .MOUSE_DATA_LINE_I(src_n[3]), .TACH_I(tach),
    .WAKE_GPIO_I(gp), .SLOW_CLK_I(slow), .RET_GPIO_I(rg),
    .UART2_TXD_I(seed[0]), .FAN_PWM_I(seed[2:1]), .RET_ALT_I(seed[3]),
    .WAKE_EVENT_OUT_N_O(ev_n), .WAKE_EVENT_OE_O(ev_oe),
    .FAN_CTL_PIN_A_O(fan_a), .FAN_CTL_PIN_B_O(fan_b),
    .IR_TX_GPIO_A_O(ir_a), .IR_TX_GPIO_B_O(ir_b), .LAMP_PIN_A_O(lamp_a),
    .LAMP_PIN_B_O(lamp_b), .RET_GPIO_O(ret_o), .RET_GPIO_OE_O(ret_oe));
  tpw_pme_host host (.clk_i(clk), .out_n_i(ev_n), .oe_i(ev_oe),
    .line_o(pme), .wakes_o(wakes));

  task check(input [31:0] got, input [31:0] exp);
    begin
      total_checks = total_checks + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task pin(input v, input e);
    check({31'h0000_0000, v}, {31'h0000_0000, e});
  endtask
  task cyc(input integer n);
    repeat (n) @(posedge clk);
  endtask
  task bus(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge clk);
      adr <= a;
      wr_en <= w;
      rd_en <= !w;
      wdat <= d;
      n = 0;
      @(posedge clk);
      while (wait_rq !== 1'b0 && n < 100) begin
        @(posedge clk);
        n = n + 1;
      end
      if (n == 100)
        miscompares = miscompares + 1;
      wr_en <= 1'b0;
      rd_en <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [31:0] e);
    begin
      expq.push_back(e);
      bus(1'b0, a, 32'h0000_0000);
    end
  endtask
  // One keyboard frame: start, code LSB first, parity, stop
  task kbd_frame(input [7:0] code);
    integer b;
    reg [10:0] f;
    begin
      f = {2'b11, code, 1'b0};
      for (b = 0; b < 11; b = b + 1) begin
        src_n[2] <= f[b];
        cyc(4);
        kclk <= 1'b0;
        cyc(4);
        kclk <= 1'b1;
      end
      src_n[2] <= 1'b1;
      cyc(8);
    end
  endtask
  task end_of_test;
    begin
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask

  // Result monitor takes the oldest expectation
  always @(posedge clk)
    if (rd_en && wait_rq === 1'b0)
      check(rdat, expq.pop_front());

  initial begin
    #(25 * 40000);
    miscompares = miscompares + 1;
    end_of_test;
  end

  initial begin : main
    integer a, k;
    cyc(12);
    rst_n <= 1'b1;
    cyc(4);
    for (a = 0; a < 8; a = a + 1)
      rd(a == 6 ? 8'hF0 : 8'(a * 4), 32'h0000_0000);
    rd(8'h18, 32'h0000_0001);
    bus(1'b1, 8'h04, 32'h0000_FF7F);
    bus(1'b1, 8'h10, 32'h0000_000A);
    bus(1'b1, 8'h0C, 32'h0000_0011);
    for (k = 0; k < 6; k = k + 1) begin
      vcc <= 1'b0;
      cyc(6);
      gi = seed[2:0];
      if (k < 4)
        src_n[k] <= 1'b0;
      else if (k == 4)
        gp[gi] <= ~gp[gi];
      else
        tach[0] <= ~tach[0];
      cyc(2500);
      pin(pme, 1'b0);
      pin(lamp_a & lamp_b, 1'b1);
      rd(8'h00, 32'h0000_0000);
      src_n <= 4'hF;
      vcc <= 1'b1;
      cyc(6);
      rd(8'h00, k < 4 ? 32'h0000_0001 << k :
        (k == 4 ? 32'h0000_0100 << gi : 32'h0000_0020));
      pin(pme, 1'b0);
      bus(1'b1, 8'h00, 32'h0000_FFFF);
      cyc(4);
      pin(pme, 1'b1);
    end
    check({24'h00_0000, wakes}, 32'h0000_0006);
    pin(ret_oe & ret_o, 1'b1);
    bus(1'b1, 8'hF0, 32'h0000_0001);
    rd(8'hF0, 32'h0000_0001);
    vcc <= 1'b0;
    cyc(6);
    tach[1] <= 1'b1;
    cyc(2500);
    pin(pme, 1'b1);
    vcc <= 1'b1;
    cyc(2500);
    rd(8'h00, 32'h0000_0040);
    bus(1'b1, 8'h00, 32'h0000_FFFF);
    bus(1'b1, 8'h08, 32'h0000_007F);
    rd(8'h08, 32'h0000_007F);
    cyc(4);
    @(posedge clk);
    u = seed[3:0];
    @(posedge clk);
    pin(ir_a, u[0]);
    check({30'h0000_0000, fan_b, fan_a}, {30'h0000_0000, ~u[2:1]});
    vcc <= 1'b0;
    cyc(6);
    pin(fan_a & fan_b, 1'b1);
    pin(ir_a | ir_b, 1'b0);
    vcc <= 1'b1;
    for (k = 0; k < 2; k = k + 1) begin
      bus(1'b1, 8'h08, 32'h0000_0007);
      cyc(4);
      pin(fan_a & fan_b, 1'b1);
      if (k == 1)
        hrst <= 1'b1;
      else
        mpor <= 1'b1;
      cyc(6);
      pin(fan_a | fan_b | ir_a, 1'b0);
      mpor <= 1'b0;
      hrst <= 1'b0;
      cyc(4);
      rd(8'h08, 32'h0000_0000);
      rd(8'h04, 32'h0000_FF7F);
    end
    bus(1'b1, 8'h14, 32'h0000_005A);
    kbd_frame(8'hA5);
    rd(8'h00, 32'h0000_0004);
    kbd_frame(8'h5A);
    rg <= 1'b1;
    cyc(6);
    rd(8'h00, 32'h0000_0094);
    rd(8'h18, 32'h0000_001F);
    cyc(4);
    end_of_test;
  end
endmodule
